/* rtl/reset_strap_memory_select.v */
// strap capture at reset, bank select decode and bus access stretching
// Function
// - emulation, adapt, boot straps at hardware reset only
// - demux and narrow bus straps at both resets
// - decode select count straps; 1,1 gives five
// - decode segment straps into segment line count
// - clock factor straps sampled at both resets
// - with CAN only twenty address lines driven
// - byte lanes from address bit zero, high enable
// - model 1 selects 0 to 3 map one-to-one onto the four banks; select 4 has no bank
// - model 0 decodes address with bank_select_0 only
// - each wait or tristate step adds 12 cycles of the 250 MHz clock (48 ns)
// - nmi triggers on falling edge
// - after reset bank_select_0 covers all space
// - model 0 lines 18,19 pick one of four banks
`include "strap_consts.vh"
`default_nettype none
module reset_strap_memory_select
(
	// clock and resets
	input  wire        clock,
	input  wire        rst_n,
	input  wire        sw_reset_n,
	// strap levels on the data port
	input  wire        emulation_strap,
	input  wire        adapt_strap,
	input  wire        boot_loader_strap,
	input  wire        demux_bus_strap,
	input  wire        narrow_bus_strap,
	input  wire        select_count_strap_lo,
	input  wire        select_count_strap_hi,
	input  wire        segment_strap_lo,
	input  wire        segment_strap_hi,
	input  wire [2:0]  clock_factor_strap,
	// controller side bus request
	input  wire        memory_model,
	input  wire        can_enable,
	input  wire [23:0] address,
	input  wire        byte_high_enable,
	input  wire        access_start,
	input  wire [3:0]  wait_state_field,
	input  wire [3:0]  tristate_field,
	input  wire [4:0]  window_hit,
	input  wire        nmi_in,
	// captured configuration
	output reg         emulation_mode,
	output reg         adapt_mode,
	output reg         boot_loader_mode,
	output reg         demux_bus_mode,
	output reg         narrow_bus_mode,
	output reg  [2:0]  select_count,
	output reg  [3:0]  segment_lines,
	output reg  [2:0]  clock_factor,
	// bank selects, active low
	output reg         bank_select_0_n,
	output reg         bank_select_1_n,
	output reg         bank_select_2_n,
	output reg         bank_select_3_n,
	output reg         bank_select_4_n,
	output reg         flash_1_sel_n,
	output reg         ram_1_sel_n,
	output reg         ram_2_sel_n,
	output reg         flash_2_sel_n,
	output reg         low_byte_sel_n,
	output reg         high_byte_sel_n,
	output reg  [23:0] address_out,
	// access timing and nmi
	output reg         access_busy,
	output reg         bus_float,
	output reg         nmi_pulse
);

// ------------------------------------------------------------
// strap capture
// ------------------------------------------------------------
// captured on every clock while reset is held, so the value at release is kept
reg        nmi_reg;
reg        nmi_pulse_next;
reg [7:0]  count_reg;
reg [7:0]  count_next;
reg [1:0]  acc_state_reg;
reg [1:0]  acc_state_next;
reg [3:0]  tf_reg;
reg [3:0]  tf_next;
reg        busy_next;
reg        float_next;
reg [4:0]  win_reg;
reg [2:0]  csn_dec;
reg [3:0]  seg_dec;

always @*
begin
	case ({select_count_strap_hi, select_count_strap_lo})
		2'b11:   csn_dec = `CSN_11;
		2'b10:   csn_dec = `CSN_10;
		2'b01:   csn_dec = `CSN_01;
		default: csn_dec = `CSN_00;
	endcase
	case ({segment_strap_hi, segment_strap_lo})
		2'b11:   seg_dec = `SEG_11;
		2'b10:   seg_dec = `SEG_10;
		2'b01:   seg_dec = `SEG_01;
		default: seg_dec = `SEG_00;
	endcase
end

always @(posedge clock)
begin
	if (!rst_n)
	begin
		// low pin selects its mode
		emulation_mode   <= ~emulation_strap;
		adapt_mode       <= ~adapt_strap;
		boot_loader_mode <= ~boot_loader_strap;
	end
	if (!rst_n || !sw_reset_n)
	begin
		demux_bus_mode  <= ~demux_bus_strap;
		narrow_bus_mode <= ~narrow_bus_strap;
		select_count    <= csn_dec;
		segment_lines   <= seg_dec;
		clock_factor    <= clock_factor_strap;
	end
end

// ------------------------------------------------------------
// bank select decode
// ------------------------------------------------------------
wire any_other = |win_reg[4:1];
wire [1:0] bank_idx = address[`BANK_ADDR_HI:`BANK_ADDR_LO];

// a window at or above the strapped select count has no pin, so its hit is dropped
wire [4:0] window_enable = {select_count > 3'h4, select_count > 3'h3,
	select_count > 3'h2, select_count > 3'h1, 1'b0};
reg  [3:0] mem_sel_next;

// order is flash 2, ram 2, ram 1, flash 1; model 0 decodes only under window 0
always @*
begin
	if (memory_model)
	begin
		mem_sel_next = {~win_reg[3], ~win_reg[2], ~win_reg[1], any_other};
	end
	else
	begin
		case (bank_idx)
			2'h0:    mem_sel_next = {3'h7, any_other};
			2'h1:    mem_sel_next = {2'h3, any_other, 1'b1};
			2'h2:    mem_sel_next = {1'b1, any_other, 2'h3};
			default: mem_sel_next = {any_other, 3'h7};
		endcase
	end
end

always @(posedge clock)
begin
	if (!rst_n || !sw_reset_n)
	begin
		win_reg         <= 5'h00;
		bank_select_0_n <= 1'b1;
		bank_select_1_n <= 1'b1;
		bank_select_2_n <= 1'b1;
		bank_select_3_n <= 1'b1;
		bank_select_4_n <= 1'b1;
		flash_1_sel_n   <= 1'b1;
		ram_1_sel_n     <= 1'b1;
		ram_2_sel_n     <= 1'b1;
		flash_2_sel_n   <= 1'b1;
		low_byte_sel_n  <= 1'b1;
		high_byte_sel_n <= 1'b1;
		address_out     <= 24'h000000;
	end
	else
	begin
		// windows beyond 0 honoured only when the strapped select count covers them
		win_reg <= window_hit & window_enable;
		bank_select_0_n <= any_other;
		bank_select_1_n <= ~win_reg[1];
		bank_select_2_n <= ~win_reg[2];
		bank_select_3_n <= ~win_reg[3];
		bank_select_4_n <= ~win_reg[4];
		flash_1_sel_n <= mem_sel_next[0];
		ram_1_sel_n   <= mem_sel_next[1];
		ram_2_sel_n   <= mem_sel_next[2];
		flash_2_sel_n <= mem_sel_next[3];
		// narrow bus uses low lane only
		low_byte_sel_n  <= address[0];
		high_byte_sel_n <= narrow_bus_mode | byte_high_enable;
		if (can_enable)
			address_out <= {4'h0, address[`CAN_ADDR_LINES-1:0]};
		else
			address_out <= address;
	end
end

// ------------------------------------------------------------
// access stretching
// ------------------------------------------------------------
// one step is 12 cycles of the 250 MHz clock; limits wait to 15 steps
// spans are formed wide and cut to the counter width on purpose
localparam [1:0] ACC_IDLE  = `BUS_ACC_IDLE;
localparam [1:0] ACC_WAIT  = `BUS_ACC_WAIT;
localparam [1:0] ACC_FLOAT = `BUS_ACC_FLOAT;

wire [31:0] wait_span  = wait_state_field * `WAIT_STEP_CYC;
wire [31:0] float_span = tf_reg * `WAIT_STEP_CYC;

always @*
begin
	acc_state_next = acc_state_reg;
	count_next     = count_reg;
	tf_next        = tf_reg;
	busy_next      = access_busy;
	float_next     = bus_float;
	case (acc_state_reg)
		ACC_IDLE:
		begin
			float_next = 1'b0;
			// a start seen while busy or floating is dropped, not queued
			if (access_start)
			begin
				tf_next        = tristate_field;
				count_next     = wait_span[7:0];
				busy_next      = 1'b1;
				acc_state_next = ACC_WAIT;
			end
		end
		ACC_WAIT:
		begin
			if (count_reg == 8'h00)
			begin
				busy_next      = 1'b0;
				float_next     = 1'b1;
				count_next     = float_span[7:0];
				acc_state_next = ACC_FLOAT;
			end
			else
			begin
				count_next = count_reg - 8'h01;
			end
		end
		ACC_FLOAT:
		begin
			if (count_reg == 8'h00)
			begin
				float_next     = 1'b0;
				acc_state_next = ACC_IDLE;
			end
			else
			begin
				count_next = count_reg - 8'h01;
			end
		end
		default:
		begin
			acc_state_next = ACC_IDLE;
		end
	endcase
end

always @(posedge clock)
begin
	if (!rst_n)
	begin
		acc_state_reg <= ACC_IDLE;
		count_reg     <= 8'h00;
		tf_reg        <= 4'h0;
		access_busy   <= 1'b0;
		bus_float     <= 1'b0;
	end
	else
	begin
		acc_state_reg <= acc_state_next;
		count_reg     <= count_next;
		tf_reg        <= tf_next;
		access_busy   <= busy_next;
		bus_float     <= float_next;
	end
end

// ------------------------------------------------------------
// nmi edge
// ------------------------------------------------------------
// pin rests high, so the stored level starts high and release gives no false edge
always @*
begin
	nmi_pulse_next = nmi_reg & ~nmi_in;
end

always @(posedge clock)
begin
	if (!rst_n)
	begin
		nmi_reg   <= 1'b1;
		nmi_pulse <= 1'b0;
	end
	else
	begin
		nmi_reg   <= nmi_in;
		nmi_pulse <= nmi_pulse_next;
	end
end

endmodule
`default_nettype wire

/* rtl/strap_consts.vh */
// constants for the reset strap loader and bank select decoder
`ifndef STRAP_CONSTS_VH
`define STRAP_CONSTS_VH
`define CLK_MHZ            250
`define OSC_MHZ            20
`define WAIT_STEP_NS       50
`define WAIT_STEP_CYC      ((`WAIT_STEP_NS * `CLK_MHZ) / 1000)
`define FIELD_W            4
`define CAN_ADDR_LINES     20
`define SEG_11             4'h2
`define SEG_10             4'h8
`define SEG_01             4'h0
`define SEG_00             4'h4
`define CSN_11             3'h5
`define CSN_10             3'h0
`define CSN_01             3'h2
`define CSN_00             3'h3
`define BANK_ADDR_LO       18
`define BANK_ADDR_HI       19
`define BUS_ACC_IDLE       2'h0
`define BUS_ACC_WAIT       2'h1
`define BUS_ACC_FLOAT      2'h2
`endif

/* tb/strap_select_monitor.sv */
// assertions on the strap loader and bank select ports
`default_nettype none
module strap_select_monitor (
	input wire logic        clock, rst_n, sw_reset_n, memory_model, can_enable,
	input wire logic        select_count_strap_lo, select_count_strap_hi, nmi_in,
	input wire logic        access_start, emulation_mode, bank_select_0_n, ram_1_sel_n,
	input wire logic        low_byte_sel_n, access_busy, bus_float, nmi_pulse,
	input wire logic [2:0]  select_count,
	input wire logic [3:0]  wait_state_field, tristate_field,
	input wire logic [4:0]  window_hit,
	input wire logic [23:0] address, address_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_go;
		access_start && !access_busy && !bus_float && wait_state_field == 4'h0
			&& tristate_field == 4'h0;
	endsequence
	sequence s_access;
		access_busy ##1 (bus_float && !access_busy) ##1 !bus_float;
	endsequence
	property p_access; s_go |=> s_access; endproperty
	a_access: assert property (p_access) else $error("access timing wrong");
	property p_em; $past(rst_n) |-> $stable(emulation_mode); endproperty
	a_em: assert property (p_em) else $error("emulation mode moved");
	property p_cnt;
		!sw_reset_n && select_count_strap_hi && select_count_strap_lo |=> select_count == 3'h5;
	endproperty
	a_cnt: assert property (p_cnt) else $error("select count wrong");
	property p_can;
		$past(rst_n) && $past(sw_reset_n) && $past(can_enable)
			|-> address_out == {4'h0, $past(address[19:0])};
	endproperty
	a_can: assert property (p_can) else $error("upper address not masked");
	property p_lane;
		$past(rst_n) && $past(sw_reset_n) |-> low_byte_sel_n == $past(address[0]);
	endproperty
	a_lane: assert property (p_lane) else $error("low lane wrong");
	property p_m0; !$past(memory_model) && !ram_1_sel_n |-> $past(address[19:18]) == 2'h1;
	endproperty
	a_m0: assert property (p_m0) else $error("model 0 bank wrong");
	property p_cs0;
		$past(rst_n) && $past(sw_reset_n) && $past(memory_model) && select_count == 3'h5
			&& ($past(window_hit, 2) & 5'h1E) == 5'h00 |-> !bank_select_0_n;
	endproperty
	a_cs0: assert property (p_cs0) else $error("default select missing");
	property p_nmi; $fell(nmi_in) |=> nmi_pulse ##1 !nmi_pulse; endproperty
	a_nmi: assert property (p_nmi) else $error("nmi pulse wrong");
endmodule
bind reset_strap_memory_select strap_select_monitor u_strap_select_monitor (.*);
`default_nettype wire

/* tb/bank_memories.sv */
// model of the on-board flash and ram devices
`default_nettype none
module bank_memories (
	input wire logic       flash_1_sel_n, ram_1_sel_n, ram_2_sel_n, flash_2_sel_n,
	output logic     [2:0] bank_hit
);
	timeunit 1ns;
	timeprecision 1ns;
	// a double select answers 7 so overlap is caught
	always_comb
	begin
		case ({flash_2_sel_n, ram_2_sel_n, ram_1_sel_n, flash_1_sel_n})
		4'hE: bank_hit = 3'h1;
		4'hD: bank_hit = 3'h2;
		4'hB: bank_hit = 3'h3;
		4'h7: bank_hit = 3'h4;
		4'hF: bank_hit = 3'h0;
		default: bank_hit = 3'h7;
		endcase
	end
endmodule
`default_nettype wire

/* tb/tb_reset_strap_memory_select.sv */
// self-checking bench for the strap loader and bank select decoder
`default_nettype none
module tb_reset_strap_memory_select;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, rst_n = 0, sw_reset_n = 1, memory_model = 1, nmi_in = 1, emulation_strap = 0;
	logic adapt_strap = 1, boot_loader_strap = 1, demux_bus_strap = 0, narrow_bus_strap = 1;
	logic select_count_strap_lo = 1, select_count_strap_hi = 1, segment_strap_lo = 0;
	logic segment_strap_hi = 0, can_enable = 0, byte_high_enable = 1, access_start = 0;
	logic [2:0] clock_factor_strap = 3'h0, select_count, clock_factor, bank_hit;
	logic [3:0] wait_state_field = 4'h0, tristate_field = 4'h0, segment_lines;
	logic [4:0] window_hit = 5'h00, sel_exp;
	logic [23:0] address = 24'h000000, address_out;
	logic emulation_mode, adapt_mode, boot_loader_mode, demux_bus_mode, narrow_bus_mode;
	logic bank_select_0_n, bank_select_1_n, bank_select_2_n, bank_select_3_n, bank_select_4_n;
	logic flash_1_sel_n, ram_1_sel_n, ram_2_sel_n, flash_2_sel_n, low_byte_sel_n, high_byte_sel_n;
	logic access_busy, bus_float, nmi_pulse;
	int n_fail = 0, n_checks = 0, em, nb, k, w, t, i;
	int csn[4] = '{3, 2, 0, 5};
	int seg[4] = '{4, 0, 8, 2};
	reset_strap_memory_select u_reset_strap_memory_select (.*);
	bank_memories u_bank_memories (.*);
	initial forever #2 clock = ~clock;
	task chk(string n, logic [23:0] s, logic [23:0] e);
		n_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask
	task final_report;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task cyc(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	initial
	begin
		#40000;
		n_fail++;
		final_report;
	end
	initial
	begin
		void'($urandom(33540));
		em = $urandom % 8;
		emulation_strap <= em[0];
		adapt_strap <= em[1];
		boot_loader_strap <= em[2];
		repeat (2) @(posedge clock);
		rst_n <= 1;
		// hardware-only straps move after release and must not be taken again
		emulation_strap <= ~em[0];
		adapt_strap <= ~em[1];
		boot_loader_strap <= ~em[2];
		for (i = 0; i < 4; i++)
		begin
			@(posedge clock);
			{select_count_strap_hi, select_count_strap_lo} <= i[1:0];
			{segment_strap_hi, segment_strap_lo} <= i[1:0];
			nb = $urandom % 4;
			narrow_bus_strap <= nb[0];
			demux_bus_strap <= nb[1];
			clock_factor_strap <= $urandom % 8;
			sw_reset_n <= 0;
			cyc(1);
			@(posedge clock);
			sw_reset_n <= 1;
			cyc(2);
			chk("count", select_count, csn[i]);
			chk("segment", segment_lines, seg[i]);
			chk("narrow", narrow_bus_mode, !nb[0]);
			chk("demux", demux_bus_mode, !nb[1]);
			chk("factor", clock_factor, clock_factor_strap);
			chk("emulation", emulation_mode, !em[0]);
			chk("adapt", adapt_mode, !em[1]);
			chk("boot", boot_loader_mode, !em[2]);
		end
		for (i = 0; i < 16; i++)
		begin
			@(posedge clock);
			memory_model <= i[0];
			address <= $urandom;
			can_enable <= $urandom % 2;
			byte_high_enable <= $urandom % 2;
			w = i[0] ? $urandom % 5 : 0;
			window_hit <= 5'h01 << w & 5'h1E;
			cyc(3);
			k = i[0] ? w : address[19:18];
			chk("bank", bank_hit, k < 4 ? k + 1 : 0);
			sel_exp = ~(5'h01 << w);
			chk("selects", {bank_select_4_n, bank_select_3_n, bank_select_2_n, bank_select_1_n,
				bank_select_0_n}, sel_exp);
			chk("address", address_out, can_enable ? address & 24'h0FFFFF : address);
			chk("lanes", {high_byte_sel_n, low_byte_sel_n},
				{~nb[0] | byte_high_enable, address[0]});
		end
		for (i = 0; i < 5; i++)
		begin
			// one wait state first, as the slow memories need
			w = i == 0 ? 1 : i == 1 ? 0 : $urandom % 4;
			t = i == 1 ? 0 : $urandom % 4;
			@(posedge clock);
			access_start <= 1;
			wait_state_field <= w[3:0];
			tristate_field <= t[3:0];
			cyc(1);
			k = 0;
			// start is held one edge into busy, where it must be refused
			while (access_busy === 1'b1 && k < 200)
			begin
				k++;
				@(posedge clock);
				access_start <= 0;
				#1;
			end
			chk("busy", k, w * 12 + 1);
			k = 0;
			while (bus_float === 1'b1 && k < 200)
			begin
				k++;
				cyc(1);
			end
			chk("float", k, t * 12 + 1);
			cyc(2);
		end
		@(posedge clock);
		nmi_in <= 0;
		cyc(1);
		chk("nmi", nmi_pulse, 1);
		cyc(1);
		chk("nmi end", nmi_pulse, 0);
		final_report;
	end
endmodule
`default_nettype wire
